// [tb/gst_ext_src.sv]
// Purpose: External count source and gate driver facing the timer pins.
// Assumes: Bursts are requested one at a time; changes land just after pclk rising edges.
// Notes: The count line stands low between bursts, as a stopped source would.
`timescale 1ns/1ps
module gst_ext_src #(
  parameter int HALF = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [3:0] n_edges,
  input wire logic gate_closed,
  output logic ext_count_input,
  output logic gate_pin_n,
  output logic busy
);
  logic [3:0] left;
  logic [3:0] ph;
  assign busy = (left != 4'h0);
  // Each phase lasts HALF cycles, above the two-cycle minimum the pin sampler needs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 4'h0;
      ph <= 4'h0;
      ext_count_input <= 1'b0;
      gate_pin_n <= 1'b1;
    end else begin
      gate_pin_n <= gate_closed;
      if (go && !busy) begin
        left <= n_edges;
        ph <= 4'h0;
      end else if (busy) begin
        ph <= ph + 4'h1;
        if (ph == 4'h0) begin
          ext_count_input <= 1'b1;
        end else if (ph == 4'(HALF)) begin
          ext_count_input <= 1'b0;
        end else if (ph == 4'(2 * HALF - 1)) begin
          ph <= 4'h0;
          left <= left - 4'h1;
        end
      end
    end
  end
endmodule : gst_ext_src

// [tb/tb.sv]
// Purpose: Self-checking bench for the gated sixteen-bit timer.
// Assumes: Zero-wait APB slave; pin edges reach the count within six cycles.
// Notes: Internal runs allow one count of slack for the free-running divider phase.
`timescale 1ns/1ps
module tb import gst_pkg::*; ();
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic go = 0, gcl = 0, gpa = 0, cpa = 0, ino = 0, slp = 0;
  logic irq, wake, lpr, f4, f5, p4, p5, ext_in, gate_n, busy;
  logic [3:0] nn = 0, n;
  logic [15:0] c;
  logic [7:0] hv;
  int seed = 19474, n_mismatch = 0, compares = 0, cyc = 0, e, n_wake = 0, nw0 = 0;
  gst_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_pin_n(gate_n), .ext_count_input(ext_in), .gate_pin_analog(gpa), .count_pin_analog(cpa),
    .internal_oscillator_no_clkout(ino), .sleep_mode(slp), .irq(irq), .wake(wake), .lp_osc_run(lpr),
    .pin4_direction_force(f4), .pin5_direction_force(f5), .pin4_read(p4), .pin5_read(p5));
  gst_ext_src src (.pclk(pclk), .presetn(presetn), .go(go), .n_edges(nn), .gate_closed(gcl),
    .ext_count_input(ext_in), .gate_pin_n(gate_n), .busy(busy));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (wake === 1'b1) n_wake++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ====
  // Helpers
  function automatic int exp_ticks(input int cycles, input int ps);
    return cycles / (4 << ps);
  endfunction : exp_ticks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic rng(input logic [31:0] g, input int x);
    compares++;
    if ($isunknown(g) || g + 1 < x || g > x + 1) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask : rng
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rcnt();
    apb(0, GST_ADDR_CNT_LO, 0);
    c[7:0] = r[7:0];
    apb(0, GST_ADDR_CNT_HI, 0);
    c[15:8] = r[7:0];
  endtask : rcnt
  task automatic pre(input logic [15:0] v);
    apb(1, GST_ADDR_CNT_LO, {24'h0, v[7:0]});
    apb(1, GST_ADDR_CNT_HI, {24'h0, v[15:8]});
  endtask : pre
  // The on-time is w plus the three cycles of the stopping write.
  task automatic run(input logic [31:0] ctl, input int w);
    pre(16'h0000);
    apb(1, GST_ADDR_CTRL, ctl);
    repeat (w) @(posedge pclk);
    apb(1, GST_ADDR_CTRL, ctl & 32'h7e);
    rcnt();
  endtask : run
  task automatic burst(input logic [3:0] k);
    @(posedge pclk) begin go <= 1; nn <= k; end
    @(posedge pclk) go <= 0;
    do @(posedge pclk); while (busy === 1'b1);
    repeat (6) @(posedge pclk);
  endtask : burst
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // ====
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, GST_ADDR_CTRL, 0); chk(r, 32'h0);
    apb(1, GST_ADDR_CTRL, 32'hff); apb(0, GST_ADDR_CTRL, 0); chk(r, 32'h7f);
    apb(1, GST_ADDR_CTRL, 0); apb(0, 8'h1c, 0); chk(err, 1); chk(r, 0);
    $display("test regs done");
    for (int i = 0; i < 5; i++) begin
      run(1 | (i % 4) << 4 | (i / 4) << 2, 190); rng(c, exp_ticks(192, i % 4));
    end
    $display("test prescale done");
    hv = 8'($random(seed)) & 8'hfe;
    pre({hv, 8'hff}); apb(1, GST_ADDR_CNT_LO, 32'h80); rcnt(); chk(c, {hv, 8'h80});
    apb(1, GST_ADDR_CNT_LO, 32'hff); apb(1, GST_ADDR_CTRL, 1); repeat (8) @(posedge pclk);
    apb(1, GST_ADDR_CTRL, 0); apb(0, GST_ADDR_CNT_HI, 0); chk(r, hv + 1);
    pre(16'hffff); apb(1, GST_ADDR_CTRL, 1); repeat (8) @(posedge pclk); apb(1, GST_ADDR_CTRL, 0);
    apb(0, GST_ADDR_CNT_HI, 0); chk(r, 0); apb(0, GST_ADDR_STATUS, 0); chk(r, 1);
    for (int i = 0; i < 8; i++) begin
      apb(1, GST_ADDR_IRQ_EN, i & 1); apb(1, GST_ADDR_IRQ_CTL, i >> 1); settle(); chk(irq, i == 7);
    end
    apb(1, GST_ADDR_STATUS, 0); repeat (20) @(posedge pclk); apb(0, GST_ADDR_STATUS, 0); chk(r, 1);
    apb(1, GST_ADDR_CLEAR, 1); apb(0, GST_ADDR_STATUS, 0); chk(r, 0); settle(); chk(irq, 0);
    $display("test irq done");
    @(posedge pclk) gcl <= 1;
    run(32'h41, 62); chk(c, 0); chk(p4, 1);
    @(posedge pclk) gpa <= 1;
    run(32'h41, 62); rng(c, exp_ticks(64, 0)); chk(p4, 0);
    @(posedge pclk) begin gpa <= 0; gcl <= 0; end
    run(32'h41, 62); rng(c, exp_ticks(64, 0));
    run(32'h40, 62); chk(c, 0);
    $display("test gate done");
    for (int i = 0; i < 4; i++) begin
      n = 4'(2 + {$random(seed)} % 8);
      e = (i < 2) ? n - 1 : 0;
      @(posedge pclk) begin slp <= (i == 1 || i == 2); cpa <= (i == 3); end
      pre(0); apb(1, GST_ADDR_CTRL, (i == 1) ? 7 : 3); burst(n);
      rcnt(); chk(c, e);
      apb(1, GST_ADDR_CTRL, 0);
    end
    @(posedge pclk) begin cpa <= 0; slp <= 1; nw0 = n_wake; end
    pre(16'hffff); apb(1, GST_ADDR_CLEAR, 1); apb(1, GST_ADDR_CTRL, 7); burst(2);
    chk(n_wake - nw0, 1); chk(irq, 1); apb(0, GST_ADDR_STATUS, 0); chk(r, 1);
    @(posedge pclk) slp <= 0;
    apb(1, GST_ADDR_CTRL, 0); apb(1, GST_ADDR_CLEAR, 1);
    $display("test external done");
    apb(1, GST_ADDR_CTRL, 8); settle(); chk(lpr, 0);
    @(posedge pclk) ino <= 1;
    settle(); chk(lpr, 1); chk({f4, f5}, 2'b11);
    chk({p4, p5}, 2'b00);
    $display("test oscillator done");
    tally_and_finish();
  end
endmodule : tb

// [verilog/gst_pkg.sv]
// Purpose: Shared constants and types for the gated sixteen-bit timer.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes: Narrow registers sit in the low bits; upper bits read as zero.
package gst_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] GST_ADDR_CNT_LO = 8'h00;
  localparam logic [7:0] GST_ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] GST_ADDR_STATUS = 8'h08;
  localparam logic [7:0] GST_ADDR_CLEAR = 8'h0c;
  localparam logic [7:0] GST_ADDR_CTRL = 8'h10;
  localparam logic [7:0] GST_ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] GST_ADDR_IRQ_CTL = 8'h18;

  // ==========================================================================
  // Field layout of timer_control
  localparam int GST_CTL_W = 7;
  localparam int GST_CTL_ON = 0;
  localparam int GST_CTL_CS = 1;
  localparam int GST_CTL_SYNC_BYP = 2;
  localparam int GST_CTL_LPOSC = 3;
  localparam int GST_CTL_PS_LO = 4;
  localparam int GST_CTL_PS_HI = 5;
  localparam int GST_CTL_GATE_EN = 6;
  localparam logic [6:0] GST_CTL_RESET = 7'h00;

  // Status, clear and enable share one layout; irq control holds two enables.
  localparam int GST_ST_ROLLOVER = 0;
  localparam int GST_IRQC_PERIPH = 0;
  localparam int GST_IRQC_GLOBAL = 1;

  // ==========================================================================
  // Counting constants
  localparam int GST_INSN_DIV_W = 2;
  localparam logic [1:0] GST_INSN_LAST = 2'h3;
  localparam int GST_PRE_W = 3;
  localparam logic [15:0] GST_CNT_MAX = 16'hffff;
  localparam logic [15:0] GST_CNT_ZERO = 16'h0000;

  typedef enum logic {GST_ARM_WAIT_FALL, GST_ARM_READY} gst_arm_e;

  function automatic logic [2:0] gst_pre_limit(input logic [1:0] sel);
    gst_pre_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction : gst_pre_limit

  function automatic logic gst_addr_hit(input logic [7:0] a);
    gst_addr_hit = (a == GST_ADDR_CNT_LO) || (a == GST_ADDR_CNT_HI) || (a == GST_ADDR_STATUS) ||
                   (a == GST_ADDR_CLEAR) || (a == GST_ADDR_CTRL) || (a == GST_ADDR_IRQ_EN) ||
                   (a == GST_ADDR_IRQ_CTL);
  endfunction : gst_addr_hit

endpackage : gst_pkg

// [verilog/gst_sync2.sv]
// Purpose: Two-flop synchroniser for pin levels entering the pclk domain.
// Assumes: Inputs are asynchronous levels.
// Notes: Only the second stage is visible to the rest of the block.
`timescale 1ns/1ps
module gst_sync2 import gst_pkg::*; #(
  parameter int W = 2,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;

  // ==========================================================================
  // Two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST;
      q <= RST;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule : gst_sync2

// [verilog/gst_timer.sv]
// Purpose: Gated sixteen-bit timer/counter with prescaler, APB registers and rollover interrupt.
// Assumes: pclk at 250 MHz; pins are asynchronous; sleep_mode and config inputs are pclk-domain.
// Notes: Every pin passes two flops, so the unsynchronised mode differs only in running through sleep.
// Behaviour
// - Sixteen-bit count wraps to zero, sets flag
// - Interrupt needs flag, timer, peripheral, global enables
// - Source select: instruction clock or pin rising
// - External mode waits for falling edge first
// - Prescale field divides by 1/2/4/8
// - Prescaler hidden, cleared by count writes
// - Timer-on runs timer; off ignores gate
// - Gate enabled: count only while gate low
// - Sync bypass only matters with external source
// - Unsynchronised mode counts in sleep, wakes
// - Oscillator enable acts only on internal oscillator
// - Control bit seven reads zero, resets zero
// - Analog-configured pins read as zero
// - Count byte reads always valid
// - Oscillator on forces pin directions, reads zero
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module gst_timer import gst_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_pin_n,
  input wire logic ext_count_input,
  input wire logic gate_pin_analog,
  input wire logic count_pin_analog,
  input wire logic internal_oscillator_no_clkout,
  input wire logic sleep_mode,
  output logic irq,
  output logic wake,
  output logic lp_osc_run,
  output logic pin4_direction_force,
  output logic pin5_direction_force,
  output logic pin4_read,
  output logic pin5_read
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [GST_CTL_W-1:0] ctrl;
    logic [15:0] cnt;
    logic [GST_PRE_W-1:0] pre;
    logic [GST_INSN_DIV_W-1:0] div;
    gst_arm_e arm;
    logic ext_prev;
    logic flag;
    logic irq_en;
    logic periph_en;
    logic global_en;
    logic [31:0] rdata;
    logic wake;
    logic lp_run;
    logic pin4_rd;
    logic pin5_rd;
  } gst_state_s;

  gst_state_s r_ff;
  gst_state_s nxt_r;
  logic gate_sync;
  logic ext_sync;
  logic gate_v;
  logic ext_v;
  logic ext_sel;
  logic async_mode;
  logic running;
  logic src_tick;
  logic inc;
  logic roll;
  logic acc;
  logic wr;
  logic cnt_wr;
  logic clr_wr;
  logic lp_active;
  logic rd_setup;

  gst_sync2 #(.W(2), .RST(2'b01)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({ext_count_input, gate_pin_n}),
    .q({ext_sync, gate_sync})
  );

  // ==========================================================================
  // Bus handshake
  // Zero-wait slave: read data is captured in the setup cycle so prdata is a flop.
  assign acc = psel && penable;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = acc;
  assign pslverr = acc && !gst_addr_hit(paddr);
  assign wr = acc && pwrite && gst_addr_hit(paddr);
  assign cnt_wr = wr && ((paddr == GST_ADDR_CNT_LO) || (paddr == GST_ADDR_CNT_HI));
  assign clr_wr = wr && (paddr == GST_ADDR_CLEAR) && pwdata[GST_ST_ROLLOVER];

  // ==========================================================================
  // Count path
  always_comb begin
    gate_v = gate_pin_analog ? 1'b0 : gate_sync;
    ext_v = count_pin_analog ? 1'b0 : ext_sync;
    ext_sel = r_ff.ctrl[GST_CTL_CS];
    async_mode = ext_sel && r_ff.ctrl[GST_CTL_SYNC_BYP];
    lp_active = r_ff.ctrl[GST_CTL_LPOSC] && internal_oscillator_no_clkout;
    running = r_ff.ctrl[GST_CTL_ON] && (!r_ff.ctrl[GST_CTL_GATE_EN] || !gate_v) &&
              (!sleep_mode || async_mode);
    if (ext_sel) begin
      src_tick = ext_v && !r_ff.ext_prev && (r_ff.arm == GST_ARM_READY);
    end else begin
      src_tick = (r_ff.div == GST_INSN_LAST);
    end
    inc = running && src_tick &&
          (r_ff.pre == gst_pre_limit(r_ff.ctrl[GST_CTL_PS_HI:GST_CTL_PS_LO]));
    roll = inc && (r_ff.cnt == GST_CNT_MAX);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.div = r_ff.div + 2'h1;
    nxt_r.ext_prev = ext_v;
    nxt_r.wake = roll && sleep_mode && async_mode;
    nxt_r.lp_run = lp_active;
    nxt_r.pin4_rd = (gate_pin_analog || lp_active) ? 1'b0 : gate_sync;
    nxt_r.pin5_rd = (count_pin_analog || lp_active) ? 1'b0 : ext_sync;

    // A stopped timer must see a fresh falling edge after it is started again.
    if (!r_ff.ctrl[GST_CTL_ON]) begin
      nxt_r.arm = GST_ARM_WAIT_FALL;
    end else begin
      case (r_ff.arm)
        GST_ARM_WAIT_FALL: begin
          if (!ext_v && r_ff.ext_prev) begin
            nxt_r.arm = GST_ARM_READY;
          end
        end
        GST_ARM_READY: begin
          nxt_r.arm = GST_ARM_READY;
        end
        default: begin
          nxt_r.arm = GST_ARM_WAIT_FALL;
        end
      endcase
    end

    if (running && src_tick) begin
      if (inc) begin
        nxt_r.pre = '0;
        nxt_r.cnt = r_ff.cnt + 16'h0001;
      end else begin
        nxt_r.pre = r_ff.pre + 3'h1;
      end
    end

    // Rollover wins over a clear in the same cycle so no event is lost.
    if (clr_wr) begin
      nxt_r.flag = 1'b0;
    end
    if (roll) begin
      nxt_r.flag = 1'b1;
    end

    if (wr) begin
      case (paddr)
        GST_ADDR_CNT_LO: begin
          nxt_r.cnt[7:0] = pwdata[7:0];
          nxt_r.pre = '0;
        end
        GST_ADDR_CNT_HI: begin
          nxt_r.cnt[15:8] = pwdata[7:0];
          nxt_r.pre = '0;
        end
        GST_ADDR_CTRL: begin
          nxt_r.ctrl = pwdata[GST_CTL_W-1:0];
        end
        GST_ADDR_IRQ_EN: begin
          nxt_r.irq_en = pwdata[GST_ST_ROLLOVER];
        end
        GST_ADDR_IRQ_CTL: begin
          nxt_r.periph_en = pwdata[GST_IRQC_PERIPH];
          nxt_r.global_en = pwdata[GST_IRQC_GLOBAL];
        end
        default: begin
          nxt_r.ctrl = r_ff.ctrl;
        end
      endcase
    end

    // Count bytes are sampled from the synchronised count, so every read is a whole byte.
    if (rd_setup) begin
      case (paddr)
        GST_ADDR_CNT_LO: nxt_r.rdata = {24'h000000, r_ff.cnt[7:0]};
        GST_ADDR_CNT_HI: nxt_r.rdata = {24'h000000, r_ff.cnt[15:8]};
        GST_ADDR_STATUS: nxt_r.rdata = {31'h00000000, r_ff.flag};
        GST_ADDR_CTRL: nxt_r.rdata = {25'h0000000, r_ff.ctrl};
        GST_ADDR_IRQ_EN: nxt_r.rdata = {31'h00000000, r_ff.irq_en};
        GST_ADDR_IRQ_CTL: nxt_r.rdata = {30'h00000000, r_ff.global_en, r_ff.periph_en};
        default: nxt_r.rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{ctrl: GST_CTL_RESET, cnt: GST_CNT_ZERO, pre: '0, div: '0, arm: GST_ARM_WAIT_FALL,
                ext_prev: 1'b0, flag: 1'b0, irq_en: 1'b0, periph_en: 1'b0, global_en: 1'b0,
                rdata: 32'h00000000, wake: 1'b0, lp_run: 1'b0, pin4_rd: 1'b0, pin5_rd: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = r_ff.rdata;
  assign irq = r_ff.flag && r_ff.irq_en && r_ff.periph_en && r_ff.global_en;
  assign wake = r_ff.wake;
  assign lp_osc_run = r_ff.lp_run;
  assign pin4_direction_force = r_ff.lp_run;
  assign pin5_direction_force = r_ff.lp_run;
  assign pin4_read = r_ff.pin4_rd;
  assign pin5_read = r_ff.pin5_rd;

  // ==========================================================================
  // Assertions
  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (roll && !cnt_wr) |=> (r_ff.cnt == GST_CNT_ZERO) && r_ff.flag)
    else $error("Rollover did not wrap to zero and set the flag.");

  AST_IRQ_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> r_ff.global_en && r_ff.periph_en && r_ff.irq_en && r_ff.flag)
    else $error("Interrupt raised without all enables set.");

  AST_FLAG_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(r_ff.flag) |-> $past(clr_wr) && !$past(roll))
    else $error("Rollover flag cleared without a software clear.");

  AST_INSN_RATE: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && !ext_sel) |=> !inc [*3])
    else $error("Internal source counted faster than one per four clocks.");

  AST_ARM_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_sel && r_ff.arm == GST_ARM_WAIT_FALL) |-> !inc)
    else $error("External count before a falling edge was seen.");

  AST_PRESCALE: assert property (@(posedge pclk) disable iff (!presetn)
    inc |-> r_ff.pre == gst_pre_limit(r_ff.ctrl[GST_CTL_PS_HI:GST_CTL_PS_LO]))
    else $error("Count step did not wait for the full prescale.");

  AST_PRE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> r_ff.pre == '0)
    else $error("Prescaler not cleared by a count write.");

  AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !r_ff.ctrl[GST_CTL_ON] |-> !inc)
    else $error("Timer counted while switched off.");

  AST_GATE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (r_ff.ctrl[GST_CTL_GATE_EN] && gate_v) |-> !inc)
    else $error("Timer counted while the gate was high.");

  AST_SLEEP_STOP: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_mode && !async_mode) |-> !inc)
    else $error("Synchronised timer counted during sleep.");

  AST_WAKE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    wake |-> $past(roll) && $past(sleep_mode))
    else $error("Wake without a rollover in sleep.");

  AST_CTRL_TOP: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == GST_ADDR_CTRL) |=> prdata[31:GST_CTL_W] == '0)
    else $error("Unimplemented control bits read nonzero.");

  AST_LP_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    lp_osc_run |-> pin4_direction_force && pin5_direction_force && !pin4_read && !pin5_read)
    else $error("Oscillator pins not forced while oscillator runs.");

  // The count moves only on a count step or a count write; the prescaler holds while the timer is stopped.
  AST_CNT_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (inc && !cnt_wr) |=> r_ff.cnt == $past(r_ff.cnt) + 16'h0001)
    else $error("Count step did not add exactly one.");

  AST_CNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!inc && !cnt_wr) |=> $stable(r_ff.cnt))
    else $error("Count moved without a count step or a count write.");

  AST_PRE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!running && !cnt_wr) |=> $stable(r_ff.pre))
    else $error("Prescaler moved while the timer was stopped.");

  AST_LO_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_wr && paddr == GST_ADDR_CNT_LO && !inc) |=>
      r_ff.cnt == {$past(r_ff.cnt[15:8]), $past(pwdata[7:0])})
    else $error("Low byte write did not load only the low byte.");

  AST_HI_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_wr && paddr == GST_ADDR_CNT_HI && !inc) |=>
      r_ff.cnt == {$past(pwdata[7:0]), $past(r_ff.cnt[7:0])})
    else $error("High byte write did not load only the high byte.");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (roll && clr_wr) |=> r_ff.flag)
    else $error("Clear beat a rollover in the same cycle.");

  AST_FLAG_ROSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(r_ff.flag) |-> $past(roll))
    else $error("Rollover flag set without a rollover.");

  AST_LP_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    !internal_oscillator_no_clkout |=> !lp_osc_run)
    else $error("Oscillator ran without the internal oscillator.");

  AST_ANALOG_READ: assert property (@(posedge pclk) disable iff (!presetn)
    count_pin_analog |=> !pin5_read)
    else $error("Analog count pin did not read zero.");

  AST_UNMAPPED_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_setup && !gst_addr_hit(paddr)) |=> prdata == 32'h00000000)
    else $error("Unmapped read returned nonzero data.");

  // ==========================================================================
  // Cover points
  COV_ROLL: cover property (@(posedge pclk) disable iff (!presetn) roll);
  COV_PRE8: cover property (@(posedge pclk) disable iff (!presetn)
    inc && (&r_ff.ctrl[GST_CTL_PS_HI:GST_CTL_PS_LO]));
  COV_WAKE: cover property (@(posedge pclk) disable iff (!presetn) wake);
  COV_EXT_INC: cover property (@(posedge pclk) disable iff (!presetn) inc && ext_sel);
  COV_GATED: cover property (@(posedge pclk) disable iff (!presetn)
    r_ff.ctrl[GST_CTL_ON] && r_ff.ctrl[GST_CTL_GATE_EN] && gate_v);

endmodule : gst_timer
